// *** src/ov_det_pkg.sv ***
package ov_det_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0] LIMIT_IDX = 8'h32;
  localparam logic [7:0] STAT_IDX = 8'h40;
  localparam logic [7:0] CLR_IDX = 8'h41;
  localparam logic [7:0] EN_IDX = 8'h42;
  localparam logic [7:0] STATE_IDX = 8'h43;
  localparam int IDX_LSB = 2;
  localparam int ADR_W = 10;
  // limit register layout
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 3;
  localparam int CODE_W = 5;
  localparam int CNT_MSB = 1;
  localparam int CNT_LSB = 0;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  // interrupt status layout
  localparam int STAT_W = 2;
  localparam int EV_FLAG = 0;
  localparam int EV_EXCEED = 1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  // threshold scaling: (base + code) / 2^ref_shift of the reference
  localparam logic [6:0] BASE_CODE = 7'h59;
  localparam int REF_SHIFT = 7;
  localparam int NUM_W = 7;
  // averaging period timing
  localparam int PERIOD_US = 80;
  localparam int CLK_MHZ = 50;
  localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;
  localparam int PCNT_W = 12;
  localparam int HIT_W = 3;
  localparam logic [HIT_W-1:0] HIT_MAX = 3'h4;
endpackage

// *** src/ov_threshold_calc.sv ***
`timescale 1ns/1ns
`default_nettype none
module ov_threshold_calc #(
  parameter int SAMPLE_W = 12
) (
  input wire logic [ov_det_pkg::CODE_W-1:0] code_i,
  output logic [SAMPLE_W-1:0] thresh_o
);
  logic [ov_det_pkg::NUM_W-1:0] num;

  // fits: largest sum is 120, inside seven bits
  always_comb begin
    num = ov_det_pkg::BASE_CODE + {2'h0, code_i};
  end

  // scaled to the reading, whose full scale equals the reference
  assign thresh_o = {num, {(SAMPLE_W-ov_det_pkg::REF_SHIFT){1'b0}}};
endmodule
`default_nettype wire

// *** src/local_overvoltage_detector.sv ***
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - threshold code in limit bits 7..3
// - each code step adds about 0.78 percent of reference
// - threshold = (89 + code) / 128 of reference
// - code 20 gives 109, 10 gives 99
// - flag sets when period average exceeds threshold
// - 80 us period, one comparison each
// - sample count field selects one to four
// - every consecutive period must exceed threshold
module local_overvoltage_detector #(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ov_det_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic avg_valid_i,
  input wire logic [SAMPLE_W-1:0] avg_volts_i,
  output logic ov_flag_o,
  output logic irq_o
);
  localparam logic [ov_det_pkg::PCNT_W-1:0] PERIOD_LAST =
    ov_det_pkg::PCNT_W'(ov_det_pkg::PERIOD_CYC - 1);

  // bus slave state
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [7:0] limit_r;
  logic [7:0] limit_nxt;
  logic [ov_det_pkg::STAT_W-1:0] stat_r;
  logic [ov_det_pkg::STAT_W-1:0] stat_nxt;
  logic [ov_det_pkg::STAT_W-1:0] en_r;
  logic [ov_det_pkg::STAT_W-1:0] en_nxt;
  logic irq_r;
  logic irq_nxt;
  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic [ov_det_pkg::STAT_W-1:0] clr_bits;

  // detector state
  logic [ov_det_pkg::PCNT_W-1:0] pcnt_r;
  logic [ov_det_pkg::PCNT_W-1:0] pcnt_nxt;
  logic [SAMPLE_W-1:0] volts_r;
  logic [SAMPLE_W-1:0] volts_nxt;
  logic [ov_det_pkg::HIT_W-1:0] hit_r;
  logic [ov_det_pkg::HIT_W-1:0] hit_nxt;
  logic flag_r;
  logic flag_nxt;
  logic period_end;
  logic exceed;
  logic [ov_det_pkg::HIT_W-1:0] need;
  logic [ov_det_pkg::HIT_W-1:0] hit_inc;
  logic [ov_det_pkg::CODE_W-1:0] thr_code;
  logic [SAMPLE_W-1:0] thresh;
  logic ev_flag;
  logic ev_exceed;

  assign req = cyc_i & stb_i;
  assign idx = adr_i[ov_det_pkg::ADR_W-1:ov_det_pkg::IDX_LSB];
  // writes land on the edge where ack is seen high
  assign wr_en = req & we_i & ack_r & sel_i[0];

  assign thr_code = limit_r[ov_det_pkg::CODE_MSB:ov_det_pkg::CODE_LSB];
  assign need = {1'b0, limit_r[ov_det_pkg::CNT_MSB:ov_det_pkg::CNT_LSB]} + 3'h1;

  ov_threshold_calc #(
    .SAMPLE_W(SAMPLE_W)
  ) u_thresh (
    .code_i(thr_code),
    .thresh_o(thresh)
  );

  // period timer and comparison
  assign period_end = (pcnt_r == PERIOD_LAST);
  assign exceed = (volts_r > thresh);
  // saturates so a long overvoltage never wraps back under the need
  assign hit_inc = (hit_r == ov_det_pkg::HIT_MAX) ? hit_r : hit_r + 3'h1;

  always_comb begin
    pcnt_nxt = period_end ? '0 : pcnt_r + 1'b1;
    volts_nxt = avg_valid_i ? avg_volts_i : volts_r;
    hit_nxt = hit_r;
    flag_nxt = flag_r;
    if (period_end) begin
      if (exceed) begin
        hit_nxt = hit_inc;
        flag_nxt = (hit_inc >= need);
      end else begin
        hit_nxt = '0;
        flag_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcnt_r <= '0;
      volts_r <= '0;
      hit_r <= '0;
      flag_r <= 1'b0;
    end else begin
      pcnt_r <= pcnt_nxt;
      volts_r <= volts_nxt;
      hit_r <= hit_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign ev_flag = flag_nxt & ~flag_r;
  assign ev_exceed = period_end & exceed;

  // register file
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdat_nxt = rdat_r;
    limit_nxt = limit_r;
    en_nxt = en_r;
    clr_bits = '0;
    if (req & ~ack_r) begin
      rdat_nxt = '0;
      unique case (idx)
        ov_det_pkg::LIMIT_IDX: rdat_nxt[7:0] = limit_r;
        ov_det_pkg::STAT_IDX: rdat_nxt[ov_det_pkg::STAT_W-1:0] = stat_r;
        ov_det_pkg::EN_IDX: rdat_nxt[ov_det_pkg::STAT_W-1:0] = en_r;
        ov_det_pkg::STATE_IDX: rdat_nxt[4:0] = {hit_r, exceed, flag_r};
        default: rdat_nxt = '0;
      endcase
    end
    if (wr_en) begin
      unique case (idx)
        // bit 2 is kept for readback only and steers nothing
        ov_det_pkg::LIMIT_IDX: limit_nxt = dat_i[7:0];
        ov_det_pkg::CLR_IDX: clr_bits = dat_i[ov_det_pkg::STAT_W-1:0];
        ov_det_pkg::EN_IDX: en_nxt = dat_i[ov_det_pkg::STAT_W-1:0];
        default: clr_bits = '0;
      endcase
    end
    // a new event beats a clear in the same cycle
    stat_nxt = (stat_r & ~clr_bits);
    stat_nxt[ov_det_pkg::EV_FLAG] = stat_nxt[ov_det_pkg::EV_FLAG] | ev_flag;
    stat_nxt[ov_det_pkg::EV_EXCEED] = stat_nxt[ov_det_pkg::EV_EXCEED] | ev_exceed;
    irq_nxt = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      limit_r <= ov_det_pkg::LIMIT_RST;
      stat_r <= ov_det_pkg::STAT_RST;
      en_r <= ov_det_pkg::STAT_RST;
      irq_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      limit_r <= limit_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;
  assign ov_flag_o = flag_r;
  assign irq_o = irq_r;

  // checks
  localparam int T_ZERO = 89;
  localparam int T_TEN = 99;
  localparam int T_TWENTY = 109;
  localparam int T_MAX = 120;
  localparam int SCALE = 1 << (SAMPLE_W - ov_det_pkg::REF_SHIFT);

  logic [ov_det_pkg::PCNT_W-1:0] gap_r;
  logic seen_end_r;

  // helper: cycles since the previous period end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r <= '0;
      seen_end_r <= 1'b0;
    end else begin
      gap_r <= period_end ? '0 : gap_r + 1'b1;
      seen_end_r <= seen_end_r | period_end;
    end
  end

  sequence s_hit_period;
    period_end && exceed;
  endsequence

  sequence s_miss_period;
    period_end && !exceed;
  endsequence

  a_code_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    thr_code == 5'h00 |-> int'(thresh) == T_ZERO * SCALE)
    else $error("code zero threshold wrong");

  a_code_max: assert property (@(posedge clk_i) disable iff (rst_i)
    thr_code == 5'h1f |-> int'(thresh) == T_MAX * SCALE)
    else $error("top code threshold wrong");

  a_code_step: assert property (@(posedge clk_i) disable iff (rst_i)
    thr_code != 5'h00 && $stable(thr_code) |->
      int'(thresh) == T_ZERO * SCALE + int'(thr_code) * SCALE)
    else $error("threshold step per code wrong");

  a_thresh_formula: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(limit_r) |=> int'(thresh) ==
      (T_ZERO + int'($past(limit_r[7:3]))) * SCALE)
    else $error("threshold does not follow new code");

  a_code_mid: assert property (@(posedge clk_i) disable iff (rst_i)
    (thr_code == 5'h14 |-> int'(thresh) == T_TWENTY * SCALE) and
    (thr_code == 5'h0a |-> int'(thresh) == T_TEN * SCALE))
    else $error("code ten or twenty threshold wrong");

  a_flag_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_r) |-> $past(period_end) && $past(exceed))
    else $error("flag rose without an exceeding period");

  a_period_len: assert property (@(posedge clk_i) disable iff (rst_i)
    period_end && seen_end_r |-> int'(gap_r) == ov_det_pkg::PERIOD_CYC - 1)
    else $error("averaging period length wrong");

  a_one_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    s_hit_period and need == 3'h1 |=> flag_r)
    else $error("single sample did not set flag");

  a_needs_all: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_r) |-> $past(hit_r) + 3'h1 >= $past(need))
    else $error("flag set before enough periods");

  a_miss_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    s_miss_period |=> hit_r == '0 && !flag_r)
    else $error("miss did not clear the count");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_r) |-> stat_r[ov_det_pkg::EV_FLAG] [*2])
    else $error("flag event not held in status");

  sequence s_bus_req;
    cyc_i && stb_i && !ack_r;
  endsequence

  // a single-cycle ack keeps a slow master from seeing a phantom second answer
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> ack_r ##1 !ack_r)
    else $error("bus ack not a single pulse");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req && !we_i && idx > ov_det_pkg::STATE_IDX |=> rdat_r == '0)
    else $error("unmapped read not zero");

  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_r == |(stat_r & en_r))
    else $error("interrupt level disagrees with status");

  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_flag |=> stat_r[ov_det_pkg::EV_FLAG])
    else $error("flag event lost to a clear");

  a_exceed_event: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_exceed |=> stat_r[ov_det_pkg::EV_EXCEED])
    else $error("exceed event not recorded");

  // the flag is only decided once per period, never between comparisons
  a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !period_end |=> $stable(flag_r))
    else $error("flag moved between period ends");

  a_hit_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_r <= ov_det_pkg::HIT_MAX)
    else $error("hit count past saturation");

  a_bit2_inert: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(limit_r[2]) && $stable(limit_r[7:3]) && $stable(limit_r[1:0]) |->
      $stable(thresh) && $stable(need))
    else $error("reserved bit steered the detector");
endmodule
`default_nettype wire

// *** dv/adc_feed.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_feed (
  input wire logic clk_i,
  input wire logic [11:0] lvl_i,
  output logic valid_o,
  output logic [11:0] volts_o
);
  logic [1:0] ph_r = 2'h0;
  always_ff @(posedge clk_i) begin
    ph_r <= ph_r + 2'h1;
  end
  // off-strobe data is junk, so the block must honour valid
  assign valid_o = (ph_r == 2'h0);
  assign volts_o = valid_o ? lvl_i : ~lvl_i;
endmodule
`default_nettype wire

// *** dv/local_overvoltage_detector_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module local_overvoltage_detector_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, avg_valid_i, ov_flag_o, irq_o;
  logic [11:0] avg_volts_i, thr, lvl = 12'h0, pc = 12'h0;
  logic [4:0] codes[5] = '{5'h00, 5'h0a, 5'h14, 5'h1f, 5'h00};
  logic [31:0] exp_q[$];
  int err_total = 0, check_count = 0;
  always #10 clk_i = ~clk_i;
  // mirrors the 4000-cycle period so every per() after the first spans exactly one period end
  always @(posedge clk_i) pc <= (rst_i || pc == 12'd3999) ? 12'h0 : pc + 12'h1;
  local_overvoltage_detector local_overvoltage_detector_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .avg_valid_i(avg_valid_i), .avg_volts_i(avg_volts_i),
    .ov_flag_o(ov_flag_o), .irq_o(irq_o));
  adc_feed adc_feed_inst (.clk_i(clk_i), .lvl_i(lvl), .valid_o(avg_valid_i),
    .volts_o(avg_volts_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    logic got;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // ack is read mid-cycle so the release follows the edge that takes the write
    do begin
      @(negedge clk_i);
      got = ack_o;
      @(posedge clk_i);
      n++;
    end while (got !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic per(input logic [11:0] v);
    lvl <= v;
    do @(posedge clk_i); while (pc != 12'd2000);
  endtask
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      check(dat_o, exp_q.pop_front(), "read data");
    end
  end
  initial begin
    repeat (95000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hdb56));
    codes[4] = 5'($urandom);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(10'h0c8, 32'h0);
    rd(10'h3fc, 32'h0);
    wb(1'b1, 10'h0c8, {24'h0, codes[4], 3'h4});
    rd(10'h0c8, {24'h0, codes[4], 3'h4});
    per(12'h0);
    for (int i = 0; i < 5; i++) begin
      thr = (12'd89 + 12'(codes[i])) * 12'd32;
      wb(1'b1, 10'h0c8, {24'h0, codes[i], 3'h0});
      per(thr);
      check(ov_flag_o, 1'b0, "flag at limit");
      per(thr + 12'h1);
      check(ov_flag_o, 1'b1, "flag above limit");
    end
    wb(1'b1, 10'h108, 32'h1);
    wb(1'b1, 10'h104, 32'h3);
    check(irq_o, 1'b0, "irq after clear");
    wb(1'b1, 10'h0c8, {24'h0, 5'h0a, 3'h3});
    thr = 12'd3168;
    per(thr);
    repeat (3) per(thr + 12'h1);
    check(ov_flag_o, 1'b0, "flag after three");
    rd(10'h10c, 32'h0e);
    per(thr);
    rd(10'h10c, 32'h00);
    repeat (3) per(thr + 12'h1);
    check(ov_flag_o, 1'b0, "flag after restart");
    per(thr + 12'h1);
    check(ov_flag_o, 1'b1, "flag after four");
    check(irq_o, 1'b1, "irq raised");
    rd(10'h100, 32'h3);
    wb(1'b1, 10'h108, 32'h0);
    check(irq_o, 1'b0, "irq masked");
    end_of_test();
  end
endmodule
`default_nettype wire
